// file: rtl/psp_defines.svh
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// register address space seen through the port
`define PSP_ADDR_W          16
`define PSP_OFF_W           15
`define PSP_OFF1B_W         7

// local register image (low address bits select a byte)
`define PSP_MEM_AW          8
`define PSP_MEM_DEPTH       256

// page register windows, one-byte and two-byte offset modes
`define PSP_PAGE_WIN_1B     5'h1f
`define PSP_PAGE_LO_1B      7'h7c
`define PSP_PAGE_HI_1B      7'h7d
`define PSP_PAGE_OFF_2B     15'h7ffd

// page register layout: bits 15..7 of the register address
`define PSP_PAGE_W          9
`define PSP_PAGE_RST        9'h000
`define PSP_PAGE_A15_POS    8
`define PSP_PAGE_A7_POS     0

// first byte fields
`define PSP_RW_POS          7
`define PSP_BIT_LAST        3'h7

`endif

// file: rtl/psp_mem.sv
`include "psp_defines.svh"
`default_nettype none

module psp_mem
  import psp_pkg::*;
(
  psp_mem_if.mem_side m
);

  logic [7:0] mem_q [0:`PSP_MEM_DEPTH-1];
  logic [7:0] lk_rdata_reg;
  logic [7:0] sys_rdata_reg;

  // only the link side writes, so no cell has two clock drivers
  always_ff @(posedge m.lk_clk)
  begin
    if (m.lk_we)
    begin
      mem_q[m.lk_waddr] <= m.lk_wdata;
    end
    lk_rdata_reg <= mem_q[m.lk_raddr];
  end

  // system read port; a read during a link write may return old data
  always_ff @(posedge m.sys_clk)
  begin
    if (m.sys_ce)
    begin
      sys_rdata_reg <= mem_q[m.sys_raddr];
    end
  end

  assign m.lk_rdata  = lk_rdata_reg;
  assign m.sys_rdata = sys_rdata_reg;

endmodule

`default_nettype wire

// file: rtl/psp_mem_if.sv
`default_nettype none

interface psp_mem_if;
  // link side, one write and one read port on the link clock
  logic       lk_clk;
  logic       lk_we;
  logic [7:0] lk_waddr;
  logic [7:0] lk_wdata;
  logic [7:0] lk_raddr;
  logic [7:0] lk_rdata;
  // system side, read only
  logic       sys_clk;
  logic       sys_ce;
  logic [7:0] sys_raddr;
  logic [7:0] sys_rdata;

  modport port_side
  (
    output lk_clk, lk_we, lk_waddr, lk_wdata, lk_raddr,
    input  lk_rdata,
    output sys_clk, sys_ce, sys_raddr,
    input  sys_rdata
  );

  modport mem_side
  (
    input  lk_clk, lk_we, lk_waddr, lk_wdata, lk_raddr,
    output lk_rdata,
    input  sys_clk, sys_ce, sys_raddr,
    output sys_rdata
  );
endinterface

`default_nettype wire

// file: rtl/psp_pkg.sv
`default_nettype none

package psp_pkg;

  // one-hot phase of an access within a chip-select frame
  typedef enum logic [2:0]
  {
    PSP_ST_CMD  = 3'b001,
    PSP_ST_ADR2 = 3'b010,
    PSP_ST_DATA = 3'b100
  } psp_state_t;

endpackage

`default_nettype wire

// file: rtl/psp_port.sv
// Overview of operation
// - internal byte pointer advances by one after each data byte.
// - one-byte offset: msb is read flag, low seven bits are address.
// - one-byte offset: page set by burst write at 0x7c, a7 then a15..a8.
// - two-byte offset write: msb clear, fifteen address bits, then data.
// - two-byte offset read: msb set, fifteen address bits, data returned.
// - optional extra half clock delay on read data output.
// - data pin released to high impedance once chip select goes high.
// - two-byte offset: page bit a15 written by burst at 0x7ffd.
// - four-wire default with separate pins, three-wire shares the data pin.
`include "psp_defines.svh"
`default_nettype none

module psp_port
  import psp_pkg::*;
(
  // system clock domain
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  // configuration, static while chip select is low
  input  wire logic       cfg_three_wire_i,
  input  wire logic       cfg_two_byte_i,
  input  wire logic       cfg_read_delay_i,
  input  wire logic       cfg_edge_fall_i,
  // serial link pins
  input  wire logic       sclk_i,
  input  wire logic       cs_i,
  input  wire logic       serial_data_input_pin_i,
  input  wire logic       sdio_i,
  output logic            sdio_o,
  output logic            sdio_oe_o,
  // system side view of the register image, frame status and write pulse
  input  wire logic [7:0] sys_raddr_i,
  output logic      [7:0] sys_rdata_o,
  output logic            frame_active_o,
  output logic            spi_write_o
);

  psp_mem_if mif ();

  // link clock: inversion picks the sampling edge
  logic link_clk;
  assign link_clk = sclk_i ^ cfg_edge_fall_i;

  logic       rst_meta_reg;
  logic       rst_sync_reg;
  logic [2:0] cfg_meta_reg;
  logic [2:0] cfg_sync_reg;
  wire  logic cfg_w3  = cfg_sync_reg[0]; // synced wire mode
  wire  logic cfg_2b  = cfg_sync_reg[1];
  wire  logic cfg_dly = cfg_sync_reg[2];

  // level crossings from the system domain, two flops each
  always_ff @(posedge link_clk)
  begin
    rst_meta_reg <= rst_b_i;
    rst_sync_reg <= rst_meta_reg;
    cfg_meta_reg <= {cfg_read_delay_i, cfg_two_byte_i, cfg_three_wire_i};
    cfg_sync_reg <= cfg_meta_reg;
  end

  psp_state_t                  state_reg;
  psp_state_t                  state_next;
  logic [2:0]                  bit_cnt_reg;
  logic [2:0]                  bit_cnt_next;
  logic [6:0]                  shift_reg;
  logic [6:0]                  shift_next;
  logic                        rw_reg;
  logic                        rw_next;
  logic [`PSP_OFF_W-1:0]       off_reg;
  logic [`PSP_OFF_W-1:0]       off_next;
  logic [`PSP_PAGE_W-1:0]      page_reg;
  logic [`PSP_PAGE_W-1:0]      page_next;
  logic                        wr_tgl_reg;
  logic                        wr_tgl_next;
  logic                        din;
  logic [7:0]                  rx;
  logic                        byte_done;
  logic                        mem_we;
  logic [`PSP_OFF_W-1:0]       off_inc;
  logic [`PSP_ADDR_W-1:0]      eff_addr;
  logic [`PSP_ADDR_W-1:0]      eff_addr_next;
  logic                        in_page_win;

  // 16-bit register address from page bits and the offset pointer
  function automatic logic [`PSP_ADDR_W-1:0] form_addr
  (
    input logic                   two_b,
    input logic [`PSP_PAGE_W-1:0] page,
    input logic [`PSP_OFF_W-1:0]  off
  );
    if (two_b)
    begin
      form_addr = {page[`PSP_PAGE_A15_POS], off};
    end
    else
    begin
      form_addr = {page, off[`PSP_OFF1B_W-1:0]};
    end
  endfunction

  // next-state decode of the address and data phases
  always_comb
  begin
    din          = cfg_w3 ? sdio_i : serial_data_input_pin_i;
    rx           = {shift_reg, din};
    byte_done    = (bit_cnt_reg == `PSP_BIT_LAST);
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg + 3'h1;
    shift_next   = rx[6:0];
    rw_next      = rw_reg;
    off_next     = off_reg;
    page_next    = page_reg;
    wr_tgl_next  = wr_tgl_reg;
    mem_we       = 1'b0;
    // one-byte mode wraps the pointer inside the 128-byte page
    off_inc = cfg_2b ? off_reg + 15'h0001
                     : {8'h00, off_reg[6:0] + 7'h01};
    if (cfg_2b)
    begin
      in_page_win = (off_reg >= `PSP_PAGE_OFF_2B);
    end
    else
    begin
      in_page_win = (off_reg[6:2] == `PSP_PAGE_WIN_1B);
    end
    if (byte_done)
    begin
      case (state_reg)
        PSP_ST_CMD:
        begin
          rw_next = rx[`PSP_RW_POS];
          if (cfg_2b)
          begin
            off_next   = {rx[6:0], 8'h00};
            state_next = PSP_ST_ADR2;
          end
          else
          begin
            off_next   = {8'h00, rx[6:0]};
            state_next = PSP_ST_DATA;
          end
        end
        PSP_ST_ADR2:
        begin
          off_next   = {off_reg[14:8], rx};
          state_next = PSP_ST_DATA;
        end
        PSP_ST_DATA:
        begin
          if (!rw_reg)
          begin
            if (in_page_win)
            begin
              // trailing bytes of the page burst are accepted and dropped
              if (cfg_2b && off_reg == `PSP_PAGE_OFF_2B)
              begin
                page_next[`PSP_PAGE_A15_POS] = rx[7];
              end
              else if (!cfg_2b && off_reg[6:0] == `PSP_PAGE_LO_1B)
              begin
                page_next[`PSP_PAGE_A7_POS] = rx[7];
              end
              else if (!cfg_2b && off_reg[6:0] == `PSP_PAGE_HI_1B)
              begin
                page_next[`PSP_PAGE_W-1:1] = rx;
              end
            end
            else
            begin
              mem_we      = 1'b1;
              wr_tgl_next = ~wr_tgl_reg;
            end
          end
          off_next = off_inc;
        end
        default:
        begin
          state_next = PSP_ST_CMD;
        end
      endcase
    end
    eff_addr      = form_addr(cfg_2b, page_reg, off_reg);
    eff_addr_next = form_addr(cfg_2b, page_next, off_next);
  end

  // frame registers; chip select high clears them without a clock
  always_ff @(posedge link_clk or posedge cs_i)
  begin
    if (cs_i)
    begin
      state_reg   <= PSP_ST_CMD;
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 7'h00;
      rw_reg      <= 1'b0;
      off_reg     <= 15'h0000;
    end
    else
    begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      rw_reg      <= rw_next;
      off_reg     <= off_next;
    end
  end

  // page survives across frames; only reset clears it
  always_ff @(posedge link_clk)
  begin
    if (!rst_sync_reg)
    begin
      page_reg   <= `PSP_PAGE_RST;
      wr_tgl_reg <= 1'b0;
    end
    else
    begin
      page_reg   <= page_next;
      wr_tgl_reg <= wr_tgl_next;
    end
  end

  // register image: write the received byte, prefetch the next one
  assign mif.lk_clk    = link_clk;
  assign mif.lk_we     = mem_we;
  assign mif.lk_waddr  = eff_addr[`PSP_MEM_AW-1:0];
  assign mif.lk_wdata  = rx;
  assign mif.lk_raddr  = eff_addr_next[`PSP_MEM_AW-1:0];
  assign mif.sys_clk   = sys_clk_i;
  assign mif.sys_ce    = ce_i;
  assign mif.sys_raddr = sys_raddr_i;
  assign sys_rdata_o   = mif.sys_rdata;

  psp_mem u_mem
  (
    .m (mif.mem_side)
  );

  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic       drive_reg;
  logic       drive_next;
  logic       dly_bit_reg;
  logic       dly_drive_reg;

  // launch on the edge opposite to sampling, loading at each byte start
  always_comb
  begin
    drive_next = (state_reg == PSP_ST_DATA) && rw_reg;
    tx_next = (drive_next && bit_cnt_reg == 3'h0) ? mif.lk_rdata
                                                  : {tx_reg[6:0], 1'b0};
  end

  always_ff @(negedge link_clk or posedge cs_i)
  begin
    if (cs_i)
    begin
      tx_reg    <= 8'h00;
      drive_reg <= 1'b0;
    end
    else
    begin
      tx_reg    <= tx_next;
      drive_reg <= drive_next;
    end
  end

  // half-period delayed copy, re-timed on the sampling edge
  always_ff @(posedge link_clk or posedge cs_i)
  begin
    if (cs_i)
    begin
      dly_bit_reg   <= 1'b0;
      dly_drive_reg <= 1'b0;
    end
    else
    begin
      dly_bit_reg   <= tx_reg[7];
      dly_drive_reg <= drive_reg;
    end
  end

  // same pin carries read data in both wire modes
  assign sdio_o    = cfg_dly ? dly_bit_reg : tx_reg[7];
  assign sdio_oe_o = cfg_dly ? dly_drive_reg : drive_reg;

  logic       cs_meta_reg;
  logic       cs_sync_reg;
  logic [2:0] wr_sync_reg;
  logic       cs_sync_next;
  logic [2:0] wr_sync_next;
  logic       active_reg;
  logic       active_next;
  logic       wr_pulse_reg;
  logic       wr_pulse_next;

  // toggle edge becomes a one-cycle write pulse; first flop read only by second
  always_comb
  begin
    cs_sync_next  = cs_meta_reg;
    wr_sync_next  = {wr_sync_reg[1:0], wr_tgl_reg};
    active_next   = ~cs_sync_reg;
    wr_pulse_next = wr_sync_reg[2] ^ wr_sync_reg[1];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      cs_meta_reg  <= 1'b1;
      cs_sync_reg  <= 1'b1;
      wr_sync_reg  <= 3'h0;
      active_reg   <= 1'b0;
      wr_pulse_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      cs_meta_reg  <= cs_i;
      cs_sync_reg  <= cs_sync_next;
      wr_sync_reg  <= wr_sync_next;
      active_reg   <= active_next;
      wr_pulse_reg <= wr_pulse_next;
    end
  end

  assign frame_active_o = active_reg;
  assign spi_write_o    = wr_pulse_reg;

endmodule

`default_nettype wire

// file: test/psp_host_model.sv
`default_nettype none

module psp_host_model
(
  // link pins
  output logic     sclk_o,
  output logic     cs_o,
  output logic     mosi_o,
  output logic     hoe_o,
  input  wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pol = 1'b0; // idle level of sclk, first edge samples
  logic dly = 1'b0; // read data expected half a period late

  initial
  begin
    cs_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    hoe_o = 1'b0;
  end

  // edges with cs high, only to move the port's link flops
  task automatic clocks(input int n);
    repeat (n)
    begin
      #24 sclk_o = ~pol;
      #24 sclk_o = pol;
    end
  endtask

  // one burst in one frame, its last cut bits left unsent, host drive dropped after the address on reads
  task automatic xfer(input logic [7:0] tx[$], input int nadr, input int cut,
                      output logic [7:0] rx[$]);
    logic [7:0] b;
    int left;
    left = tx.size() * 8 - cut;
    rx = {};
    cs_o = 1'b0;
    hoe_o = 1'b1;
    foreach (tx[i])
    begin
      if (i >= nadr && tx[0][7])
        hoe_o = 1'b0;
      for (int k = 7; k >= 0 && left > 0; k--)
      begin
        mosi_o = tx[i][k];
        left--;
        #24;
        if (!dly)
          b[k] = miso_i;
        sclk_o = ~pol;
        #24;
        if (dly)
          b[k] = miso_i;
        sclk_o = pol;
      end
      rx.push_back(b);
    end
    #24;
    cs_o = 1'b1;
    hoe_o = 1'b0;
    mosi_o = ~mosi_o; // released line must not echo the last bit
    #200;
  endtask
endmodule

`default_nettype wire

// file: test/psp_port_assertions.sv
`default_nettype none

module psp_port_chk
(
  // system domain
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic cfg_three_wire_i,
  input wire logic cfg_two_byte_i,
  input wire logic cfg_read_delay_i,
  input wire logic cfg_edge_fall_i,
  // link pins
  input wire logic sclk_i,
  input wire logic cs_i,
  input wire logic serial_data_input_pin_i,
  input wire logic sdio_i,
  input wire logic sdio_oe_o,
  // status
  input wire logic frame_active_o,
  input wire logic spi_write_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] cnt_reg, cnt_next;
  logic       rw_reg, rw_next;
  wire  [5:0] nadr = cfg_two_byte_i ? 6'h10 : 6'h08;

  // bits seen in the frame, saturating so long bursts stay cheap
  always_comb
  begin
    cnt_next = (cnt_reg == 6'h3f) ? cnt_reg : cnt_reg + 6'h01;
    rw_next = (cnt_reg == 6'h00) ? (cfg_three_wire_i ? sdio_i : serial_data_input_pin_i)
                                 : rw_reg;
  end

  // cleared by cs like the port, since sclk stops between frames
  always_ff @(posedge sclk_i or posedge cs_i)
    {cnt_reg, rw_reg} <= cs_i ? 7'h00 : {cnt_next, rw_next};

  sequence s_frame_up;
    ##[1:6] frame_active_o;
  endsequence
  sequence s_frame_down;
    ##[1:6] !frame_active_o;
  endsequence

  property p_frame_on;
    @(posedge sys_clk_i) disable iff (!rst_b_i) $fell(cs_i) |-> s_frame_up;
  endproperty
  property p_frame_off;
    @(posedge sys_clk_i) disable iff (!rst_b_i) $rose(cs_i) |-> s_frame_down;
  endproperty
  property p_oe_idle;
    @(posedge sys_clk_i) disable iff (!rst_b_i) cs_i |-> !sdio_oe_o;
  endproperty
  property p_wr_pulse;
    @(posedge sys_clk_i) disable iff (!rst_b_i) $rose(spi_write_o) |=> !spi_write_o [*3];
  endproperty
  property p_oe_nodly;
    @(posedge sclk_i) disable iff (cs_i || cfg_edge_fall_i)
      !cfg_read_delay_i && rw_reg && cnt_reg >= nadr |-> sdio_oe_o;
  endproperty
  property p_oe_dly;
    @(negedge sclk_i) disable iff (cs_i || cfg_edge_fall_i)
      cfg_read_delay_i && rw_reg && cnt_reg > nadr |-> sdio_oe_o;
  endproperty
  property p_oe_wr;
    @(posedge sclk_i) disable iff (cs_i || cfg_edge_fall_i)
      cnt_reg != 6'h00 && !rw_reg |-> !sdio_oe_o;
  endproperty
  property p_oe_addr;
    @(posedge sclk_i) disable iff (cs_i || cfg_edge_fall_i) cnt_reg < nadr |-> !sdio_oe_o;
  endproperty

  a_frame_on: assert property (p_frame_on) else $error("frame flag late");
  a_frame_off: assert property (p_frame_off) else $error("frame flag stuck");
  a_oe_idle: assert property (p_oe_idle) else $error("data pin driven idle");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse long");
  a_oe_nodly: assert property (p_oe_nodly) else $error("read data late");
  a_oe_dly: assert property (p_oe_dly) else $error("delayed data late");
  a_oe_wr: assert property (p_oe_wr) else $error("driven in write");
  a_oe_addr: assert property (p_oe_addr) else $error("driven in address");
endmodule

bind psp_port psp_port_chk chk_u
(
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cfg_three_wire_i(cfg_three_wire_i),
  .cfg_two_byte_i(cfg_two_byte_i), .cfg_read_delay_i(cfg_read_delay_i),
  .cfg_edge_fall_i(cfg_edge_fall_i), .sclk_i(sclk_i), .cs_i(cs_i),
  .serial_data_input_pin_i(serial_data_input_pin_i), .sdio_i(sdio_i),
  .sdio_oe_o(sdio_oe_o), .frame_active_o(frame_active_o), .spi_write_o(spi_write_o)
);

`default_nettype wire

// file: test/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        three_w = 1'b0;
  logic        two_b = 1'b0;
  logic        rd_dly = 1'b0;
  logic        fall = 1'b0;
  logic [7:0]  raddr = 8'h00;
  logic        sclk, cs, mosi, hoe, sdo, sdo_oe, act, wr_p;
  logic [7:0]  rdata;
  logic [7:0]  mem [256];
  logic [15:0] page = 16'h0000;
  int          fail_count = 0;
  int          tests_run = 0;
  int          pulses = 0;
  int          exp_p = 0;
  // shared data wire: device wins, else host in three-wire, else garbage
  wire sdio_w = sdo_oe ? sdo : ((hoe && three_w) ? mosi : ~mosi);

  psp_port dut_u
  (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .cfg_three_wire_i(three_w), .cfg_two_byte_i(two_b), .cfg_read_delay_i(rd_dly),
    .cfg_edge_fall_i(fall), .sclk_i(sclk), .cs_i(cs), .serial_data_input_pin_i(mosi),
    .sdio_i(sdio_w), .sdio_o(sdo), .sdio_oe_o(sdo_oe), .sys_raddr_i(raddr),
    .sys_rdata_o(rdata), .frame_active_o(act), .spi_write_o(wr_p)
  );
  psp_host_model host_u
  (
    .sclk_o(sclk), .cs_o(cs), .mosi_o(mosi), .hoe_o(hoe), .miso_i(sdio_w)
  );

  initial
    forever #12.5 sys_clk_i = ~sys_clk_i;

  // count image write pulses away from the edge that launches them
  always @(negedge sys_clk_i)
    if (wr_p === 1'b1)
      pulses++;

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  function automatic logic [7:0] idx(input logic [14:0] o);
    return two_b ? o[7:0] : {page[7], o[6:0]};
  endfunction

  task automatic wr_model(input logic [14:0] o, input logic [7:0] v);
    if (!two_b && o[6:2] == 5'h1f)
    begin
      if (o[1:0] == 2'b00)
        page[7] = v[7];
      if (o[1:0] == 2'b01)
        page[15:8] = v;
    end
    else if (two_b && o >= 15'h7ffd)
      page[15] = (o == 15'h7ffd) ? v[7] : page[15];
    else
    begin
      mem[idx(o)] = v;
      exp_p++;
    end
  endtask

  task automatic spi(input logic rd, input logic [14:0] off, input logic [7:0] d[$],
                     input int cut);
    logic [7:0]  tx[$];
    logic [7:0]  rx[$];
    logic [14:0] o;
    int          na;
    na = two_b ? 2 : 1;
    tx = {};
    if (two_b)
      tx.push_back({rd, off[14:8]});
    tx.push_back(two_b ? off[7:0] : {rd, off[6:0]});
    tx = {tx, d};
    host_u.xfer(tx, na, cut, rx);
    foreach (d[i])
    begin
      o = two_b ? off + 15'(i) : {8'h00, off[6:0] + 7'(i)};
      if (rd)
        chk(mem[idx(o)], rx[na + i]);
      else if (cut == 0)
        wr_model(o, d[i]);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog, about eight times the expected run
  initial
  begin
    #1ms;
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    logic [14:0] off;
    logic [7:0]  d[$];
    int          p0;
    int          e0;
    void'($urandom(32'h1f9d));
    fork
      host_u.clocks(4);
      repeat (16) @(negedge sys_clk_i);
    join
    rst_b_i = 1'b1;
    // every mode, wiring, delay and edge combination
    for (int m = 0; m < 16; m++)
    begin
      @(negedge sys_clk_i);
      {fall, rd_dly, three_w, two_b} = 4'(m);
      host_u.pol = fall;
      host_u.dly = rd_dly;
      host_u.clocks(4);
      if (two_b)
        spi(1'b0, 15'h7ffd, '{8'h80, 8'h10, 8'h20}, 0);
      else
        spi(1'b0, 15'h007c, '{8'($urandom), 8'($urandom), 8'h10, 8'h20}, 0);
      off = two_b ? 15'($urandom_range(32'h7ff0)) : 15'($urandom_range(32'h78));
      d = '{8'($urandom), 8'($urandom), 8'($urandom)};
      p0 = pulses;
      e0 = exp_p;
      spi(1'b0, off, d, 0);
      repeat (10) @(negedge sys_clk_i);
      chk(8'(exp_p - e0), 8'(pulses - p0));
      spi(1'b0, off, '{~d[0]}, 3);
      spi(1'b1, off, '{8'h00, 8'h00, 8'h00}, 0);
      @(negedge sys_clk_i);
      raddr = idx(off);
      repeat (2) @(negedge sys_clk_i);
      chk(mem[raddr], rdata);
      ce_i = 1'b0;
      raddr = ~raddr;
      repeat (2) @(negedge sys_clk_i);
      chk(mem[~raddr], rdata);
      ce_i = 1'b1;
      $display("test %0d done", m);
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire
